// *** bench/mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_model
   import trap_pkg::*;
(
   input wire logic pclk,
   input wire mem_req_s mem_req,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] wa[$], wd[$], ra[$];
   // acks a cycle late; data flips when idle so no stale word passes
   always @(posedge pclk) begin
      mem_ack <= mem_req.valid && mem_ack !== 1'b1;
      mem_rdata <= mem_req.valid ? ~mem_req.addr : ~mem_rdata;
      if (mem_ack && mem_req.valid && mem_req.write) begin
         wa.push_back(mem_req.addr);
         wd.push_back(mem_req.wdata);
      end
      if (mem_ack && mem_req.valid && !mem_req.write) ra.push_back(mem_req.addr);
   end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
   import trap_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nmi_pin = 1'b0;
   logic ext_reset_pin_n = 1'b1, watchdog_expired = 1'b0, pready, pslverr, mem_ack, er;
   logic pipeline_hold, pins_reset, ext_reset_vector, mode_reserved;
   logic [2:0] mode_pins = PINS_EXT_VEC_16;
   logic [15:0] paddr = 16'h0, irq_req = 16'h0;
   logic [79:0] irq_level = {70'h0, 5'h05, 5'h05};
   logic [31:0] pwdata = 32'h0, general_register_fifteen = 32'h0ff8, prdata, mem_rdata;
   logic [31:0] rd, lpc, lgr, sp;
   logic [1:0] gear_select, bus_mode;
   logic [11:0] area_width;
   instr_info_s instr = 48'h0;
   mem_req_s mem_req;
   word_load_s pc_load, gr15_load;
   int miscompares = 0, checked = 0;
   trap_entry_reset_mode DUT (.*);
   mem_model mem (.*);
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) if (pc_load.valid) lpc <= pc_load.value;
   always @(posedge pclk) if (gr15_load.valid) lgr <= gr15_load.value;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wt(input logic v);
      for (int n = 0; pipeline_hold !== v; n++) begin
         if (n > 99) begin
            miscompares++;
            give_verdict();
         end
         @(negedge pclk);
      end
      @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      for (int n = 0; n < 9; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) begin
         miscompares++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic fire(input instr_kind_e k, input length_e l, input logic [7:0] op);
      mem.wa.delete();
      mem.ra.delete();
      instr <= {1'b1, k, l, 2'b00, op, 32'h0100};
      @(posedge pclk) instr.done <= 1'b0;
      wt(1'b1);
      wt(1'b0);
   endtask
   task automatic trap(input instr_kind_e k, input length_e l, input logic [7:0] op,
         input logic [31:0] ret, input logic [31:0] vec);
      fire(k, l, op);
      chk(mem.wa[0], sp - 4);
      chk(mem.wa[1], sp - 8);
      chk(mem.wd[mem.wd.size() - 1], ret);
      chk(lpc, ~(TABLE_BASE_RESET + vec));
      sp = sp - 8;
   endtask
   task automatic t_reset;
      wt(1'b0);
      apb(1'b0, STATUS_WORD_ADDR, 32'h0);
      chk(rd, STATUS_RESET);
      chk(lpc, ~RESET_VECTOR_ADDR);
      $display("reset done");
   endtask
   task automatic t_mode;
      chk(32'(area_width[1:0]), 32'(WIDTH_16));
      chk(32'(ext_reset_vector), 32'h1);
      apb(1'b1, AREA_CFG_BASE_ADDR, 32'(WIDTH_8));
      apb(1'b1, MODE_SELECT_ADDR, {24'h0, BUS_INT_ROM_EXT, 6'h0});
      chk(32'(area_width[1:0]), 32'(WIDTH_8));
      apb(1'b1, MODE_SELECT_ADDR, {24'h0, BUS_EXT_ROM_EXT, 6'h0});
      chk(32'(bus_mode), 32'(BUS_INT_ROM_EXT));
      apb(1'b0, 16'h0100, 32'h0);
      chk(32'(er), 32'h1);
      $display("mode done");
   endtask
   task automatic t_traps;
      apb(1'b1, STACK_PTR_ADDR, 32'h1000);
      sp = 32'h1000;
      apb(1'b1, STATUS_WORD_ADDR, 32'h001f_0001);
      irq_req <= 16'h0003;
      trap(KIND_PLAIN, LEN_IMM32, 8'h00, 32'h0106, VEC_TOP - 32'h40);
      irq_req <= 16'h0000;
      apb(1'b0, STATUS_WORD_ADDR, 32'h0);
      chk(rd, 32'h0005_0001);
      trap(KIND_INT, LEN_OTHER, 8'h20, 32'h0102, VEC_TOP - 32'h80);
      trap(KIND_UNDEF, LEN_OTHER, 8'h00, 32'h0100, VEC_UNDEFINED);
      trap(KIND_COP_ABSENT, LEN_COPROC, 8'h00, 32'h0104, VEC_COP_ABSENT);
      trap(KIND_COP_ERROR, LEN_COPROC, 8'h00, 32'h0104, VEC_COP_ERROR);
      apb(1'b1, STATUS_WORD_ADDR, 32'h001f_0004);
      trap(KIND_PLAIN, LEN_OTHER, 8'h00, 32'h0102, VEC_STEP_TRACE);
      $display("traps done");
   endtask
   task automatic t_ret;
      fire(KIND_RETURN, LEN_OTHER, 8'h00);
      chk(mem.ra[0], 32'h0ff8);
      chk(mem.ra[1], 32'h0ffc);
      chk(lgr, 32'h1000);
      trap(KIND_EMU_TRAP, LEN_OTHER, 8'h00, 32'h0102, VEC_EMU_TRAP);
      apb(1'b0, STATUS_WORD_ADDR, 32'h0);
      chk(32'(rd[20:16]), 32'(LEVEL_DEBUG));
      $display("return done");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mode();
      t_traps();
      t_ret();
      give_verdict();
   end
endmodule
`default_nettype wire

// *** bench/trap_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module trap_checks
   import trap_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire instr_info_s instr,
   input wire mem_req_s mem_req,
   input wire logic mem_ack,
   input wire word_load_s pc_load,
   input wire logic pipeline_hold,
   input wire logic pins_reset,
   input wire logic [1:0] gear_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   gear_low_a: assert property (gear_select == 2'h0) else $error("gear");
   pins_rst_a: assert property ($rose(presetn) |-> pins_reset) else $error("pins");
   rst_vec_a: assert property (mem_req.valid && pins_reset
      |-> mem_req.addr == RESET_VECTOR_ADDR) else $error("vector");
   busy_hold_a: assert property (mem_req.valid |-> pipeline_hold) else $error("hold");
   push_order_a: assert property (mem_req.valid && mem_req.write && mem_ack ##1
      mem_req.valid && mem_req.write |-> mem_req.addr == $past(mem_req.addr) - STACK_STEP)
      else $error("push");
   pc_ack_a: assert property (pc_load.valid |-> $past(mem_ack) && !$past(mem_req.write))
      else $error("pc");
   ret_hold_a: assert property (instr.done && instr.kind == KIND_RETURN && !pipeline_hold
      |=> pipeline_hold) else $error("return");
   recheck_a: assert property (pc_load.valid && !$past(pins_reset) |-> pipeline_hold)
      else $error("recheck");
   cover property (pc_load.valid && pipeline_hold);
   cover property (mem_req.write && mem_ack);
   cover property (instr.done && instr.kind == KIND_RETURN);
endmodule
bind trap_entry_reset_mode trap_checks chk (.*);
`default_nettype wire

// *** core/trap_entry_reset_mode.sv ***
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - interrupt/NMI entry: push status, push next address, set mask, clear S, vector
// - after every entry sequence, check again for acceptable events before handler
// - software trap: push status and PC+2, clear I and S, vector 3FC-4*operand
// - emulator trap: push status and PC+2, mask 00100, clear S, vector 3D8
// - no emulator trap while stepping; software avoids it inside debug handlers
// - step trap when trace set, not delayed branch, outside debug handlers
// - step entry: push status and next address, mask 00100, clear S, vector 3CC
// - trace flag blocks user NMI, maskable interrupts and emulator traps
// - undefined outside delay slot: push status and own address, clear S, vector 3C4
// - absent coprocessor: push status and next address, clear S, vector 3E0
// - coprocessor error on next use: push status and next address, vector 3DC
// - trap return pops PC from register fifteen, then status, adding 4 each
// - reset causes: external pin, software bit, watchdog expiry, power-on
// - pin or software reset: pins to reset state, registers init, lowest gear
// - after reset cause clears, PC loads from word at 000FFFFC
// - mode pins: 000 ext 8 bit, 001 ext 16 bit, 011 internal, others reserved
// - mode register takes one write per reset, effective at once
// - bus mode bits 00 single, 01 int rom, 10 ext rom; 11 reserved
// - bus width from mode pins until mode written, then from area configs
// - lowest level wins, then lowest number; accept below mask, I for maskable
// - next address PC+6 for imm32, PC+4 imm20 or coprocessor, else PC+2
module trap_entry_reset_mode
   import trap_pkg::*;
#(
   parameter int IRQ_COUNT = 16,
   parameter bit HAS_INTERNAL_ROM = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire instr_info_s instr,
   input wire logic [31:0] general_register_fifteen,
   input wire logic [IRQ_COUNT-1:0] irq_req,
   input wire logic [5*IRQ_COUNT-1:0] irq_level,
   input wire logic nmi_pin,
   input wire logic ext_reset_pin_n,
   input wire logic watchdog_expired,
   input wire logic [2:0] mode_pins,
   output mem_req_s mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output word_load_s pc_load,
   output word_load_s gr15_load,
   output logic pipeline_hold,
   output logic pins_reset,
   output logic [1:0] gear_select,
   output logic [1:0] bus_mode,
   output logic ext_reset_vector,
   output logic mode_reserved,
   output logic [2*AREA_COUNT-1:0] area_width
);

   typedef enum {
      ST_RST_WAIT, ST_RST_VEC, ST_IDLE, ST_CHECK, ST_PUSH_STATUS,
      ST_PUSH_ADDR, ST_VEC_READ, ST_POP_PC, ST_POP_STATUS
   } state_e;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] nmi_sync, ext_rst_sync;
   logic [2:0] mode_meta, mode_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_sync <= 2'h0;
         ext_rst_sync <= 2'h0;
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
      end else begin
         nmi_sync <= {nmi_sync[0], nmi_pin};
         ext_rst_sync <= {ext_rst_sync[0], ~ext_reset_pin_n};
         mode_meta <= mode_pins;
         mode_sync <= mode_meta;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   state_e state;
   logic [31:0] program_status, system_stack_pointer, vector_table_base;
   logic [31:0] ev_pc, ev_next, ent_vec, ent_ret, ret_ptr;
   logic [7:0] ev_operand;
   instr_kind_e ev_kind;
   logic step_pend, debug_handler, ent_set_mask, ent_clear_ie, ent_debug;
   logic [4:0] ent_mask;
   logic sw_reset_req, soft_reset, reset_hold;
   logic [3:0] reset_cause;
   logic mode_written;
   logic [1:0] mode_bits;
   logic [2:0] mode_latched;
   logic [1:0] area_cfg [AREA_COUNT];

   wire logic level_mask_ok;
   wire logic [4:0] level_mask = program_status[STAT_LM_LSB +: 5];
   wire logic trace_on = program_status[STAT_T_BIT];
   wire logic ie_on = program_status[STAT_IE_BIT];

   assign reset_hold = ext_rst_sync[1] | watchdog_expired;
   assign soft_reset = reset_hold | sw_reset_req;

   // ------------------------------------------------------------
   // interrupt selection
   // ------------------------------------------------------------
   logic sel_valid, sel_nmi, irq_accept;
   logic [4:0] sel_level;
   logic [7:0] sel_num;

   always_comb begin
      sel_valid = nmi_sync[1];
      sel_nmi = nmi_sync[1];
      sel_level = LEVEL_NMI;
      sel_num = NMI_NUMBER;
      for (int i = 0; i < IRQ_COUNT; i++) begin
         // strict compare keeps the smaller number on a tie
         if (irq_req[i] && (!sel_valid || irq_level[5*i +: 5] < sel_level)) begin
            sel_valid = 1'b1;
            sel_nmi = 1'b0;
            sel_level = irq_level[5*i +: 5];
            sel_num = FIRST_MASKABLE + 8'(i);
         end
      end
      irq_accept = sel_valid && (sel_level < level_mask) && (sel_nmi || ie_on)
         && !trace_on;
   end
   assign level_mask_ok = irq_accept;

   // next instruction address by length class
   function automatic logic [31:0] next_addr(input logic [31:0] pc, input length_e len);
      case (len)
         LEN_IMM32: next_addr = pc + LEN_LONG;
         LEN_IMM20, LEN_COPROC: next_addr = pc + LEN_MEDIUM;
         default: next_addr = pc + LEN_SHORT;
      endcase
   endfunction

   // ------------------------------------------------------------
   // trap sequencer
   // ------------------------------------------------------------
   wire logic apb_wr = psel & penable & pwrite;
   wire logic hit_status = apb_wr && paddr == STATUS_WORD_ADDR;
   wire logic hit_stack = apb_wr && paddr == STACK_PTR_ADDR;
   wire logic hit_table = apb_wr && paddr == TABLE_BASE_ADDR;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_RST_WAIT;
         program_status <= STATUS_RESET;
         system_stack_pointer <= STACK_PTR_RESET;
         vector_table_base <= TABLE_BASE_RESET;
         ev_pc <= 32'h0;
         ev_next <= 32'h0;
         ev_operand <= 8'h0;
         ev_kind <= KIND_PLAIN;
         step_pend <= 1'b0;
         debug_handler <= 1'b0;
         ent_vec <= 32'h0;
         ent_ret <= 32'h0;
         ent_mask <= 5'h0;
         ent_set_mask <= 1'b0;
         ent_clear_ie <= 1'b0;
         ent_debug <= 1'b0;
         ret_ptr <= 32'h0;
      end else if (soft_reset) begin
         state <= ST_RST_WAIT;
         program_status <= STATUS_RESET;
         system_stack_pointer <= STACK_PTR_RESET;
         vector_table_base <= TABLE_BASE_RESET;
         ev_kind <= KIND_PLAIN;
         step_pend <= 1'b0;
         debug_handler <= 1'b0;
      end else begin
         if (hit_status) program_status <= pwdata;
         if (hit_stack) system_stack_pointer <= pwdata;
         if (hit_table) vector_table_base <= pwdata;
         case (state)
            ST_RST_WAIT: begin
               state <= ST_RST_VEC;
            end
            ST_RST_VEC: begin
               if (mem_ack) begin
                  ev_next <= mem_rdata;
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               // events are taken only here, so a sequence in flight defers them
               if (instr.done) begin
                  ev_pc <= instr.pc;
                  ev_next <= next_addr(instr.pc, instr.len);
                  ev_operand <= instr.operand;
                  ev_kind <= instr.kind;
                  if (instr.kind == KIND_UNDEF && instr.delay_slot) ev_kind <= KIND_PLAIN;
                  if (instr.kind == KIND_EMU_TRAP && trace_on) ev_kind <= KIND_PLAIN;
                  step_pend <= trace_on && !instr.delayed_branch && !debug_handler;
                  ret_ptr <= general_register_fifteen;
                  state <= (instr.kind == KIND_RETURN) ? ST_POP_PC : ST_CHECK;
               end
            end
            ST_CHECK: begin
               ent_set_mask <= 1'b0;
               ent_clear_ie <= 1'b0;
               ent_debug <= 1'b0;
               ent_ret <= ev_next;
               state <= ST_PUSH_STATUS;
               if (ev_kind == KIND_UNDEF) begin
                  ent_ret <= ev_pc;
                  ent_vec <= vector_table_base + VEC_UNDEFINED;
                  ev_kind <= KIND_PLAIN;
               end else if (ev_kind == KIND_INT) begin
                  ent_ret <= ev_pc + LEN_SHORT;
                  ent_clear_ie <= 1'b1;
                  ent_vec <= vector_table_base + VEC_TOP - {22'h0, ev_operand, 2'h0};
                  ev_kind <= KIND_PLAIN;
               end else if (ev_kind == KIND_COP_ABSENT) begin
                  ent_vec <= vector_table_base + VEC_COP_ABSENT;
                  ev_kind <= KIND_PLAIN;
               end else if (ev_kind == KIND_COP_ERROR) begin
                  ent_vec <= vector_table_base + VEC_COP_ERROR;
                  ev_kind <= KIND_PLAIN;
               end else if (level_mask_ok) begin
                  ent_set_mask <= 1'b1;
                  ent_mask <= sel_level;
                  ent_vec <= vector_table_base + VEC_TOP - {22'h0, sel_num, 2'h0};
               end else if (step_pend) begin
                  ent_set_mask <= 1'b1;
                  ent_mask <= LEVEL_DEBUG;
                  ent_debug <= 1'b1;
                  ent_vec <= vector_table_base + VEC_STEP_TRACE;
                  step_pend <= 1'b0;
               end else if (ev_kind == KIND_EMU_TRAP) begin
                  ent_ret <= ev_pc + LEN_SHORT;
                  ent_set_mask <= 1'b1;
                  ent_mask <= LEVEL_DEBUG;
                  ent_debug <= 1'b1;
                  ent_vec <= vector_table_base + VEC_EMU_TRAP;
                  ev_kind <= KIND_PLAIN;
               end else begin
                  ev_kind <= KIND_PLAIN;
                  state <= ST_IDLE;
               end
            end
            ST_PUSH_STATUS: begin
               if (mem_ack) begin
                  system_stack_pointer <= system_stack_pointer - STACK_STEP;
                  state <= ST_PUSH_ADDR;
               end
            end
            ST_PUSH_ADDR: begin
               if (mem_ack) begin
                  system_stack_pointer <= system_stack_pointer - STACK_STEP;
                  program_status[STAT_S_BIT] <= 1'b0;
                  if (ent_clear_ie) program_status[STAT_IE_BIT] <= 1'b0;
                  if (ent_set_mask) program_status[STAT_LM_LSB +: 5] <= ent_mask;
                  if (ent_debug) debug_handler <= 1'b1;
                  state <= ST_VEC_READ;
               end
            end
            ST_VEC_READ: begin
               if (mem_ack) begin
                  ev_next <= mem_rdata; // next entry pushes the handler start
                  state <= ST_CHECK;
               end
            end
            ST_POP_PC: begin
               if (mem_ack) begin
                  ev_next <= mem_rdata;
                  ret_ptr <= ret_ptr + STACK_STEP;
                  state <= ST_POP_STATUS;
               end
            end
            ST_POP_STATUS: begin
               if (mem_ack) begin
                  program_status <= mem_rdata;
                  ret_ptr <= ret_ptr + STACK_STEP;
                  debug_handler <= 1'b0;
                  ev_kind <= KIND_PLAIN;
                  state <= ST_CHECK;
               end
            end
            default: state <= ST_RST_WAIT;
         endcase
         if (state == ST_RST_WAIT && reset_hold) state <= ST_RST_WAIT;
      end
   end

   // ------------------------------------------------------------
   // memory, pipeline and reset outputs
   // ------------------------------------------------------------
   always_comb begin
      mem_req = '0;
      case (state)
         ST_RST_VEC: begin
            mem_req.valid = 1'b1;
            mem_req.addr = RESET_VECTOR_ADDR;
         end
         ST_PUSH_STATUS: begin
            mem_req.valid = 1'b1;
            mem_req.write = 1'b1;
            mem_req.addr = system_stack_pointer - STACK_STEP;
            mem_req.wdata = program_status;
         end
         ST_PUSH_ADDR: begin
            mem_req.valid = 1'b1;
            mem_req.write = 1'b1;
            mem_req.addr = system_stack_pointer - STACK_STEP;
            mem_req.wdata = ent_ret;
         end
         ST_VEC_READ: begin
            mem_req.valid = 1'b1;
            mem_req.addr = ent_vec;
         end
         ST_POP_PC, ST_POP_STATUS: begin
            mem_req.valid = 1'b1;
            mem_req.addr = ret_ptr;
         end
         default: mem_req = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load <= '0;
         gr15_load <= '0;
      end else begin
         pc_load.valid <= mem_ack && !soft_reset
            && (state == ST_RST_VEC || state == ST_VEC_READ || state == ST_POP_PC);
         pc_load.value <= mem_rdata;
         gr15_load.valid <= mem_ack && !soft_reset && state == ST_POP_STATUS;
         gr15_load.value <= ret_ptr + STACK_STEP;
      end
   end

   // handler issue waits for the whole sequence and the recheck
   assign pipeline_hold = state != ST_IDLE;
   assign pins_reset = state == ST_RST_WAIT || state == ST_RST_VEC;
   assign gear_select = 2'h0; // only the lowest gear is produced here

   // ------------------------------------------------------------
   // reset cause, software reset and mode control
   // ------------------------------------------------------------
   wire logic hit_mode = apb_wr && paddr == MODE_SELECT_ADDR;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_cause <= 4'h1;
         sw_reset_req <= 1'b0;
      end else begin
         sw_reset_req <= apb_wr && paddr == STANDBY_CTRL_ADDR && !pwdata[SW_RESET_BIT];
         if (soft_reset) begin
            reset_cause <= {sw_reset_req, ext_rst_sync[1], watchdog_expired, 1'b0};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_written <= 1'b0;
         mode_bits <= 2'h0;
         mode_latched <= 3'h0;
      end else if (soft_reset) begin
         mode_written <= 1'b0;
         mode_bits <= 2'h0;
         mode_latched <= mode_sync; // strap caught while reset is held
      end else if (hit_mode && !mode_written) begin
         mode_written <= 1'b1;
         mode_bits <= pwdata[BUS_MODE_LSB +: 2];
      end else if (!mode_written) begin
         mode_latched <= mode_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < AREA_COUNT; i++) area_cfg[i] <= WIDTH_8;
      end else if (soft_reset) begin
         for (int i = 0; i < AREA_COUNT; i++) area_cfg[i] <= WIDTH_8;
      end else begin
         for (int i = 0; i < AREA_COUNT; i++) begin
            if (apb_wr && paddr == AREA_CFG_BASE_ADDR + 16'(4 * i)) area_cfg[i] <= pwdata[1:0];
         end
      end
   end

   // pin decode; reserved codes fall back to the external 8 bit setting
   logic [1:0] pin_width;
   logic pin_reserved;
   always_comb begin
      pin_reserved = 1'b0;
      case (mode_latched)
         PINS_EXT_VEC_8: pin_width = WIDTH_8;
         PINS_EXT_VEC_16: pin_width = WIDTH_16;
         PINS_INT_VEC: pin_width = area_cfg[0];
         default: begin
            pin_width = WIDTH_8;
            pin_reserved = 1'b1;
         end
      endcase
   end

   assign ext_reset_vector = mode_latched != PINS_INT_VEC;
   assign bus_mode = mode_written ? mode_bits
      : (mode_latched == PINS_INT_VEC ? BUS_SINGLE_CHIP : BUS_EXT_ROM_EXT);
   assign mode_reserved = pin_reserved || (mode_written && (mode_bits == 2'h3
      || (!HAS_INTERNAL_ROM && mode_bits != BUS_EXT_ROM_EXT)));

   // software must set the area widths first, or areas left unset drop to 8 bit
   for (genvar g = 0; g < AREA_COUNT; g++) begin : g_area
      assign area_width[2*g +: 2] = mode_written ? area_cfg[g] : pin_width;
   end

   // ------------------------------------------------------------
   // apb read side
   // ------------------------------------------------------------
   logic mapped;
   logic [31:0] read_mux;
   always_comb begin
      mapped = 1'b1;
      read_mux = 32'h0;
      case (paddr)
         STANDBY_CTRL_ADDR: read_mux = 32'h1 << SW_RESET_BIT;
         STATUS_WORD_ADDR: read_mux = program_status;
         STACK_PTR_ADDR: read_mux = system_stack_pointer;
         TABLE_BASE_ADDR: read_mux = vector_table_base;
         RESET_CAUSE_ADDR: read_mux = {28'h0, reset_cause};
         MODE_STATUS_ADDR: read_mux = {24'h0, debug_handler, mode_reserved, bus_mode,
            mode_written, mode_latched};
         MODE_SELECT_ADDR: read_mux = 32'h0;
         default: begin
            mapped = 1'b0;
            for (int i = 0; i < AREA_COUNT; i++) begin
               if (paddr == AREA_CFG_BASE_ADDR + 16'(4 * i)) begin
                  mapped = 1'b1;
                  read_mux = {30'h0, area_cfg[i]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0 : read_mux;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

endmodule
`default_nettype wire

// *** core/trap_pkg.sv ***
package trap_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int AREA_COUNT = 6;
   localparam logic [15:0] STANDBY_CTRL_ADDR = 16'h0000;
   localparam logic [15:0] STATUS_WORD_ADDR = 16'h0004;
   localparam logic [15:0] STACK_PTR_ADDR = 16'h0008;
   localparam logic [15:0] TABLE_BASE_ADDR = 16'h000c;
   localparam logic [15:0] RESET_CAUSE_ADDR = 16'h0010;
   localparam logic [15:0] MODE_STATUS_ADDR = 16'h0014;
   localparam logic [15:0] AREA_CFG_BASE_ADDR = 16'h0020;
   localparam logic [10:0] MODE_SELECT_INDEX = 11'h7ff;
   localparam logic [15:0] MODE_SELECT_ADDR = {3'h0, MODE_SELECT_INDEX, 2'h0};

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int SW_RESET_BIT = 4;
   localparam int STAT_IE_BIT = 0;
   localparam int STAT_S_BIT = 1;
   localparam int STAT_T_BIT = 2;
   localparam int STAT_LM_LSB = 16;
   localparam int BUS_MODE_LSB = 6;
   localparam logic [4:0] LEVEL_MASK_RESET = 5'h0f;
   localparam logic [31:0] STATUS_RESET = {11'h000, LEVEL_MASK_RESET, 16'h0000};
   localparam logic [31:0] STACK_PTR_RESET = 32'h0000_0000;
   localparam logic [31:0] TABLE_BASE_RESET = 32'h000f_fc00;
   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] BUS_SINGLE_CHIP = 2'h0;
   localparam logic [1:0] BUS_INT_ROM_EXT = 2'h1;
   localparam logic [1:0] BUS_EXT_ROM_EXT = 2'h2;
   localparam logic [2:0] PINS_EXT_VEC_8 = 3'h0;
   localparam logic [2:0] PINS_EXT_VEC_16 = 3'h1;
   localparam logic [2:0] PINS_INT_VEC = 3'h3;

   // ------------------------------------------------------------
   // trap sequencing constants
   // ------------------------------------------------------------
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;
   localparam logic [31:0] RESET_VECTOR_ADDR = 32'h000f_fffc;
   localparam logic [31:0] VEC_TOP = 32'h0000_03fc;
   localparam logic [31:0] VEC_EMU_TRAP = 32'h0000_03d8;
   localparam logic [31:0] VEC_STEP_TRACE = 32'h0000_03cc;
   localparam logic [31:0] VEC_UNDEFINED = 32'h0000_03c4;
   localparam logic [31:0] VEC_COP_ABSENT = 32'h0000_03e0;
   localparam logic [31:0] VEC_COP_ERROR = 32'h0000_03dc;
   localparam logic [4:0] LEVEL_DEBUG = 5'h04;
   localparam logic [4:0] LEVEL_NMI = 5'h0f;
   localparam logic [7:0] NMI_NUMBER = 8'h0f;
   localparam logic [7:0] FIRST_MASKABLE = 8'h10;
   localparam logic [31:0] LEN_SHORT = 32'h0000_0002;
   localparam logic [31:0] LEN_MEDIUM = 32'h0000_0004;
   localparam logic [31:0] LEN_LONG = 32'h0000_0006;

   typedef enum logic [2:0] {
      KIND_PLAIN, KIND_INT, KIND_EMU_TRAP, KIND_UNDEF,
      KIND_COP_ABSENT, KIND_COP_ERROR, KIND_RETURN
   } instr_kind_e;

   typedef enum logic [1:0] {LEN_OTHER, LEN_IMM20, LEN_COPROC, LEN_IMM32} length_e;

   typedef struct packed {
      logic done;
      instr_kind_e kind;
      length_e len;
      logic delayed_branch;
      logic delay_slot;
      logic [7:0] operand;
      logic [31:0] pc;
   } instr_info_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] value;
   } word_load_s;

endpackage
